// >>> inc/sbrg_pkg.sv
// Package with register map, field positions and reset values of the serial port block
package sbrg_pkg;
  localparam logic [3:0] OFF_BAUD_HIGH = 4'h0;
  localparam logic [3:0] OFF_BAUD_LOW = 4'h1;
  localparam logic [3:0] OFF_CONTROL_ONE = 4'h2;
  localparam logic [3:0] OFF_ALT_STATUS_ONE = 4'h0;
  localparam logic [3:0] OFF_ALT_CONTROL_ONE = 4'h1;
  localparam logic [3:0] OFF_ALT_CONTROL_TWO = 4'h2;
  localparam logic [3:0] OFF_CONTROL_TWO = 4'h3;
  localparam logic [3:0] OFF_STATUS_ONE = 4'h4;
  localparam logic [3:0] OFF_STATUS_TWO = 4'h5;
  localparam logic [3:0] OFF_DATA_HIGH = 4'h6;
  localparam logic [3:0] OFF_DATA_LOW = 4'h7;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h9;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'hA;
  localparam logic [3:0] OFF_MODE = 4'hB;
  localparam int ADDR_LSB = 2;
  localparam int BIT_INFRARED_ENABLE = 7;
  localparam int BIT_TRANSMITTER_ENABLE = 3;
  localparam int BIT_RECEIVER_ENABLE = 2;
  localparam int BIT_ALTERNATE_MAP_SELECT = 7;
  localparam int BIT_EV_TICK = 0;
  localparam int BIT_EV_RX_LOW = 1;
  localparam int BIT_EV_GEN_STOP = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;
  localparam logic [2:0] MASK_ALT_STATUS_ONE = 3'h0;
  localparam logic [7:0] MASK_ALT_CONTROL_ONE = 8'h83;
  localparam logic [7:0] MASK_ALT_CONTROL_TWO = 8'hE7;
  localparam logic [7:0] MASK_STATUS_TWO = 8'h9F;
  localparam logic [7:0] STATUS_ONE_IDLE = 8'hC0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int NUM_EVENTS = 3;
  typedef enum logic [1:0] {OPM_RUN, OPM_WAIT, OPM_STOP} sbrg_opmode_t;
endpackage

// >>> inc/sbrg_rate_if.sv
// Interface carrying divisor, enables and tick between the register file and rate generator
`timescale 1ns/1ps
interface sbrg_rate_if;
  logic [15:0] divisor;
  logic infrared;
  logic enable;
  logic tick;
  logic running;
  modport ctrl (output divisor, output infrared, output enable, input tick, input running);
  modport gen (input divisor, input infrared, input enable, output tick, output running);
endinterface

// >>> hdl/sbrg_baud_gen.sv
// Baud rate generator counting bus clock cycles down to one tick per divisor
`timescale 1ns/1ps
module sbrg_baud_gen (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  sbrg_rate_if.gen rate
);
  logic [15:0] count;
  logic [15:0] limit;
  logic started;
  logic next_allowed;

  function automatic logic [15:0] eff_div(input logic [15:0] d, input logic ir);
    eff_div = ir ? {d[15:1], 1'b0} : d;
  endfunction

  // Too-small divisors stop the generator altogether
  always_comb begin
    if (rate.infrared) begin
      next_allowed = |limit[15:5];
    end else begin
      next_allowed = |limit[15:4];
    end
  end

  // Stays stopped from reset until the first enable
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      started <= 1'b0;
    end else if (rate.enable) begin
      started <= 1'b1;
    end
  end

  // New divisor is taken only at the start of a sample period
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      limit <= sbrg_pkg::RESET_DIVISOR;
    end else if (count == 16'h0000) begin
      limit <= eff_div(rate.divisor, rate.infrared);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !started || !rate.enable || !next_allowed) begin
      count <= 16'h0000;
      rate.tick <= 1'b0;
    end else if (count >= limit - 16'h0001) begin
      count <= 16'h0000;
      rate.tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      rate.tick <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rate.running <= 1'b0;
    end else begin
      rate.running <= started && rate.enable && next_allowed;
    end
  end
endmodule

// >>> hdl/sbrg_pin_ctl.sv
// Pin control for the transmit and receive lines
`timescale 1ns/1ps
module sbrg_pin_ctl (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic rx_pin,
  output logic tx_out,
  output logic tx_oe,
  output logic rx_level,
  output logic rx_active_low
);
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      tx_out <= 1'b1;
      tx_oe <= tx_enable;
    end
  end

  // Disabled receiver reads as an idle high line
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rx_level <= 1'b1;
      rx_active_low <= 1'b0;
    end else begin
      rx_level <= rx_enable ? rx_pin : 1'b1;
      rx_active_low <= rx_enable && !rx_pin;
    end
  end
endmodule

// >>> hdl/sbrg_top.sv
// Serial port register file with banked map, interrupts and AXI4-Lite slave
`timescale 1ns/1ps
// Notes on behaviour
// - Transmit pin idles high; undriven whenever the transmitter is off.
// - Receive pin high means idle; ignored while receiver is off.
// - Reserved locations ignore writes and read as zero.
// - Infrared off: rate is bus clock over full 16-bit divisor.
// - Infrared on: rate is bus clock over twice divisor bits 15..1.
// - Generator stopped after reset until transmitter or receiver first enabled.
// - Generator off when divisor too small for the current mode.
// - Map select zero: offsets 0..2 are divisor bytes and control one.
// - Map select one: offsets 0..2 are alternate status and controls.
// - Map select resets to zero, divisor visible after reset.
// - New divisor loads at next start of sample period.
// - Wait mode behaves as run; stop mode turns off transmitter, receiver and generator.
module sbrg_top (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [5:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [5:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RXD_IN,
  output logic TXD_OUT,
  output logic TXD_OE,
  output logic RATE_TICK,
  output logic IRQ
);
  sbrg_rate_if rate ();

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] baud_divisor;
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] alt_control_one;
  logic [7:0] alt_control_two;
  logic [7:0] status_two;
  logic [7:0] data_low;
  logic [1:0] data_high;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  sbrg_pkg::sbrg_opmode_t opmode;
  logic tx_oe_int;
  logic tx_out_int;
  logic rx_level;
  logic rx_low;
  logic running_d;
  logic [2:0] events;

  // ----------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------
  logic [5:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic do_read;

  function automatic logic [3:0] word_index(input logic [5:0] a);
    word_index = a[5:sbrg_pkg::ADDR_LSB];
  endfunction

  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign do_read = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
      S_AXI_AWREADY <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_held && !S_AXI_BVALID;
    end
  end

  // Unmapped offsets still answer OKAY; reserved space reads zero
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= sbrg_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= sbrg_pkg::RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  logic wr_lane;
  logic [3:0] widx;
  logic alternate_map_select;
  assign wr_lane = do_write && w_strb[0];
  assign widx = word_index(aw_addr);
  assign alternate_map_select = status_two[sbrg_pkg::BIT_ALTERNATE_MAP_SELECT];

  // Divisor high and low bytes as a 16-bit word at offset 0 when strobes 0 and 1 are set
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      baud_divisor <= sbrg_pkg::RESET_DIVISOR;
    end else if (do_write && !alternate_map_select) begin
      if (widx == sbrg_pkg::OFF_BAUD_HIGH) begin
        if (w_strb[0]) begin
          baud_divisor[15:8] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          baud_divisor[7:0] <= w_data[15:8];
        end
      end else if (widx == sbrg_pkg::OFF_BAUD_LOW && w_strb[0]) begin
        baud_divisor[7:0] <= w_data[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      control_one <= sbrg_pkg::RESET_BYTE;
      alt_control_one <= sbrg_pkg::RESET_BYTE;
      alt_control_two <= sbrg_pkg::RESET_BYTE;
    end else if (wr_lane && widx == sbrg_pkg::OFF_CONTROL_ONE && !alternate_map_select) begin
      control_one <= w_data[7:0];
    end else if (wr_lane && widx == sbrg_pkg::OFF_ALT_CONTROL_ONE && alternate_map_select) begin
      alt_control_one <= w_data[7:0] & sbrg_pkg::MASK_ALT_CONTROL_ONE;
    end else if (wr_lane && widx == sbrg_pkg::OFF_ALT_CONTROL_TWO && alternate_map_select) begin
      alt_control_two <= w_data[7:0] & sbrg_pkg::MASK_ALT_CONTROL_TWO;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      control_two <= sbrg_pkg::RESET_BYTE;
      status_two <= sbrg_pkg::RESET_BYTE;
      data_low <= sbrg_pkg::RESET_BYTE;
      data_high <= 2'b00;
    end else if (wr_lane && widx == sbrg_pkg::OFF_CONTROL_TWO) begin
      control_two <= w_data[7:0];
    end else if (wr_lane && widx == sbrg_pkg::OFF_STATUS_TWO) begin
      status_two <= w_data[7:0] & sbrg_pkg::MASK_STATUS_TWO;
    end else if (wr_lane && widx == sbrg_pkg::OFF_DATA_LOW) begin
      data_low <= w_data[7:0];
    end else if (wr_lane && widx == sbrg_pkg::OFF_DATA_HIGH) begin
      data_high[0] <= w_data[6];
    end
  end

  // Stop mode turns off transmitter and receiver, so the rate logic stops; run and wait behave the same
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      opmode <= sbrg_pkg::OPM_RUN;
    end else if (wr_lane && widx == sbrg_pkg::OFF_MODE) begin
      case (w_data[1:0])
        2'b01: opmode <= sbrg_pkg::OPM_WAIT;
        2'b10: opmode <= sbrg_pkg::OPM_STOP;
        default: opmode <= sbrg_pkg::OPM_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Rate generator and pins
  // ----------------------------------------
  logic tx_en;
  logic rx_en;
  logic stop_mode;
  assign stop_mode = (opmode == sbrg_pkg::OPM_STOP);
  assign tx_en = control_two[sbrg_pkg::BIT_TRANSMITTER_ENABLE] && !stop_mode;
  assign rx_en = control_two[sbrg_pkg::BIT_RECEIVER_ENABLE] && !stop_mode;
  assign rate.divisor = baud_divisor;
  assign rate.infrared = alt_control_two[sbrg_pkg::BIT_INFRARED_ENABLE];
  assign rate.enable = tx_en || rx_en;

  sbrg_baud_gen u_gen (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .rate(rate)
  );

  sbrg_pin_ctl u_pins (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .tx_enable(tx_en),
    .rx_enable(rx_en),
    .rx_pin(RXD_IN),
    .tx_out(tx_out_int),
    .tx_oe(tx_oe_int),
    .rx_level(rx_level),
    .rx_active_low(rx_low)
  );

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      TXD_OUT <= 1'b1;
      TXD_OE <= 1'b0;
      RATE_TICK <= 1'b0;
    end else begin
      TXD_OUT <= tx_out_int;
      TXD_OE <= tx_oe_int;
      RATE_TICK <= rate.tick;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      running_d <= 1'b0;
    end else begin
      running_d <= rate.running;
    end
  end

  assign events = {running_d && !rate.running, rx_low, rate.tick};

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_status <= 3'h0;
    end else if (wr_lane && widx == sbrg_pkg::OFF_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~w_data[2:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_enable <= 3'h0;
    end else if (wr_lane && widx == sbrg_pkg::OFF_IRQ_ENABLE) begin
      irq_enable <= w_data[2:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------
  // Reads
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic [3:0] ridx;
  assign ridx = word_index(S_AXI_ARADDR);

  always_comb begin
    rd_byte = 8'h00;
    if (ridx == sbrg_pkg::OFF_BAUD_HIGH) begin
      rd_byte = alternate_map_select ? {rx_low, 7'h00} : baud_divisor[15:8];
    end else if (ridx == sbrg_pkg::OFF_BAUD_LOW) begin
      rd_byte = alternate_map_select ? alt_control_one : baud_divisor[7:0];
    end else if (ridx == sbrg_pkg::OFF_CONTROL_ONE) begin
      rd_byte = alternate_map_select ? alt_control_two : control_one;
    end else if (ridx == sbrg_pkg::OFF_CONTROL_TWO) begin
      rd_byte = control_two;
    end else if (ridx == sbrg_pkg::OFF_STATUS_ONE) begin
      rd_byte = sbrg_pkg::STATUS_ONE_IDLE | {4'h0, !rx_level, 3'h0};
    end else if (ridx == sbrg_pkg::OFF_STATUS_TWO) begin
      rd_byte = status_two;
    end else if (ridx == sbrg_pkg::OFF_DATA_HIGH) begin
      rd_byte = {1'b0, data_high[0], 6'h00};
    end else if (ridx == sbrg_pkg::OFF_DATA_LOW) begin
      rd_byte = data_low;
    end else if (ridx == sbrg_pkg::OFF_IRQ_STATUS) begin
      rd_byte = {5'h00, irq_status};
    end else if (ridx == sbrg_pkg::OFF_IRQ_ENABLE) begin
      rd_byte = {5'h00, irq_enable};
    end else if (ridx == sbrg_pkg::OFF_MODE) begin
      rd_byte = {6'h00, opmode};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= sbrg_pkg::RESP_OKAY;
    end else if (do_read) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_byte};
      S_AXI_RRESP <= sbrg_pkg::RESP_OKAY;
    end else if (S_AXI_RVALID) begin
      S_AXI_RVALID <= !S_AXI_RREADY;
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule

// >>> tb/sbrg_line_partner.sv
// Far-side serial device that drives the receive line and watches the transmit line
`timescale 1ns/1ps
module sbrg_line_partner (
  input wire logic clk,
  input wire logic hold_low,
  input wire logic tx_pin,
  input wire logic tx_en,
  output logic rx_pin,
  output logic tx_line
);
  // ----
  // Line model
  // ----
  // Released transmit line is pulled up, so an undriven pin reads as idle
  assign tx_line = tx_en ? tx_pin : 1'b1;
  // Receive line idles high unless the bench asks for a low level
  always_ff @(posedge clk) begin
    rx_pin <= !hold_low;
  end
endmodule

// >>> tb/sbrg_top_checker.sv
// Assertions on the ports of the serial port block
`timescale 1ns/1ps
module sbrg_top_checker (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TXD_OUT,
  input wire logic TXD_OE,
  input wire logic RATE_TICK,
  input wire logic IRQ
);
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ----
  // Sequences
  // ----
  sequence ar_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // Smallest legal divisor is 16, so a tick is never followed closely by another
  sequence tick_gap;
    !RATE_TICK [*8];
  endsequence
  // ----
  // Properties
  // ----
  rst_state_a: assert property ($fell(SYS_RST) |->
    !TXD_OE && TXD_OUT && !IRQ && !RATE_TICK) else $error("outputs wrong after reset");
  tx_idle_a: assert property (TXD_OE |-> TXD_OUT)
    else $error("transmit pin not idle high");
  tick_space_a: assert property (RATE_TICK |=> tick_gap)
    else $error("rate ticks too close");
  read_answer_a: assert property (ar_take |-> ##[1:2] S_AXI_RVALID)
    else $error("read not answered");
  write_answer_a: assert property (wr_take |-> ##[1:3] S_AXI_BVALID)
    else $error("write not answered");
  resp_okay_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == sbrg_pkg::RESP_OKAY)
    else $error("write response not okay");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
endmodule
bind sbrg_top sbrg_top_checker chk (
  .CLOCK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .TXD_OUT, .TXD_OE, .RATE_TICK, .IRQ
);

// >>> tb/sbrg_top_tb.sv
// Self-checking testbench for the serial port register block
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module sbrg_top_tb;
  typedef struct {logic w; logic [3:0] idx; logic [7:0] d; logic [7:0] exp;} sbrg_row_t;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, hold_low, rxd, tx_line;
  logic awready, wready, bvalid, arready, rvalid, txd, txd_oe, tick, irq;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checks_done = 0;
  int p;
  time tf, t2;
  sbrg_row_t rows [17] = '{
    '{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h00}, '{1'b0, 4'h5, 8'h00, 8'h00},
    '{1'b0, 4'h4, 8'h00, 8'hC0}, '{1'b0, 4'hA, 8'h00, 8'h00}, '{1'b1, 4'hE, 8'hFF, 8'h00},
    '{1'b0, 4'hF, 8'h00, 8'h00}, '{1'b1, 4'h0, 8'h12, 8'h12}, '{1'b1, 4'h1, 8'h34, 8'h34},
    '{1'b1, 4'h2, 8'hA5, 8'hA5}, '{1'b1, 4'h5, 8'h80, 8'h80}, '{1'b1, 4'h1, 8'hFF, 8'h83},
    '{1'b1, 4'h2, 8'hFF, 8'hE7}, '{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b1, 4'h5, 8'h00, 8'h00},
    '{1'b0, 4'h1, 8'h00, 8'h34}, '{1'b0, 4'h2, 8'h00, 8'hA5}
  };
  logic rate_ir [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0] rate_div [5] = '{16'h0020, 16'h0041, 16'h001F, 16'h001F, 16'h000F};
  int rate_per [5] = '{32, 64, 0, 31, 0};

  sbrg_top dut (
    .CLOCK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .RXD_IN(rxd), .TXD_OUT(txd), .TXD_OE(txd_oe), .RATE_TICK(tick), .IRQ(irq)
  );
  sbrg_line_partner far (.clk(clk), .hold_low(hold_low), .tx_pin(txd), .tx_en(txd_oe),
    .rx_pin(rxd), .tx_line(tx_line));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d, input logic [3:0] s = 4'h1);
    int n;
    n = 0;
    awaddr <= {i, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (bready && bvalid) break;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      // Ready only once the answer shows, so the slave must hold it for a cycle
      if (bvalid) bready <= 1'b1;
    end
    if (n >= 50) n_mismatch++;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] i, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (rready && rvalid) break;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    if (n >= 50) n_mismatch++;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Divisor goes in one word so the generator never loads half of it
  task automatic rate(input logic ir, input logic [15:0] dv);
    wr(4'h5, 32'h0000_0080);
    wr(4'h2, {24'h00_0000, ir, 7'h00});
    wr(4'h5, 32'h0000_0000);
    wr(4'h0, {16'h0000, dv[7:0], dv[15:8]}, 4'h3);
  endtask

  // Time of the first tick, and the period between the second and third
  task automatic gap(output int per, output time t1);
    int k, n, t0;
    k = 0;
    per = 0;
    t1 = 0;
    t0 = 0;
    for (n = 0; n < 400 && k < 3; n++) begin
      @(posedge clk);
      if (tick === 1'b1) begin
        k++;
        if (k == 1) t1 = $time;
        if (k == 2) t0 = n;
        if (k == 3) per = n - t0;
      end
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    results();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, hold_low} = 6'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].idx, {24'h00_0000, rows[i].d});
      rd(rows[i].idx, v);
      `CHK("register", rows[i].exp, v);
      `CHK("rresp", sbrg_pkg::RESP_OKAY, rresp);
    end
    `CHK("tx_oe_off", 1'b0, txd_oe);
    `CHK("tx_line_off", 1'b1, tx_line);
    rate(1'b0, 16'h0020);
    gap(p, tf);
    `CHK("stopped", 0, p);
    wr(4'h3, 32'h0000_0008);
    `CHK("tx_oe", 1'b1, txd_oe);
    `CHK("tx_line", 1'b1, tx_line);
    foreach (rate_div[i]) begin
      rate(rate_ir[i], rate_div[i]);
      gap(p, tf);
      `CHK("period", rate_per[i], p);
    end
    // Ticks and the stop of the generator both leave sticky status bits
    rd(4'h8, v);
    `CHK("ev_tick", 1'b1, v[0]);
    `CHK("ev_stop", 1'b1, v[2]);
    // A longer divisor written mid-period must not stretch that period
    rate(1'b0, 16'h0020);
    gap(p, tf);
    repeat (4) @(posedge clk);
    wr(4'h0, 32'h0000_4000, 4'h3);
    gap(p, t2);
    `CHK("latch_point", 96, (t2 - tf) / 50);
    `CHK("new_period", 64, p);
    wr(4'hB, 32'h0000_0001);
    gap(p, tf);
    `CHK("wait_mode", 64, p);
    // Stop mode turns off transmitter and generator until run mode returns
    wr(4'hB, 32'h0000_0002);
    `CHK("stop_oe", 1'b0, txd_oe);
    gap(p, tf);
    `CHK("stop_mode", 0, p);
    wr(4'hB, 32'h0000_0000);
    // Receive line and interrupt path
    hold_low <= 1'b1;
    rd(4'h8, v);
    `CHK("rx_ignored_irq", 1'b0, v[1]);
    rd(4'h4, v);
    `CHK("rx_ignored", 8'hC0, v);
    wr(4'h3, 32'h0000_000C);
    rd(4'h4, v);
    `CHK("rx_low", 8'hC8, v);
    hold_low <= 1'b0;
    rd(4'h8, v);
    `CHK("irq_status", 1'b1, v[1]);
    wr(4'h9, 32'h0000_0002);
    `CHK("irq_on", 1'b1, irq);
    wr(4'h9, 32'h0000_0000);
    `CHK("irq_masked", 1'b0, irq);
    wr(4'h9, 32'h0000_0002);
    wr(4'hA, 32'h0000_0002);
    `CHK("irq_clear", 1'b0, irq);
    // Reset in mid-run stops the generator again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("oe_reset", 1'b0, txd_oe);
    rd(4'h5, v);
    `CHK("map_reset", 8'h00, v);
    rate(1'b0, 16'h0020);
    gap(p, tf);
    `CHK("restart", 0, p);
    results();
  end
endmodule
